// [sdbt_pkg.sv]
// sdbt_pkg: register map, fields and command codes of the timer control
// assumes word-aligned APB access, one register per 32-bit word
package sdbt_pkg;
   // register indices, byte address is index times four
   localparam logic [5:0] REG_PRESCALE = 6'h00;
   localparam logic [5:0] REG_OUT_EN   = 6'h01;
   localparam logic [5:0] REG_IDLE     = 6'h02;
   localparam logic [5:0] REG_SPLIT    = 6'h03;
   localparam logic [5:0] REG_CMD_CLR  = 6'h04;
   localparam logic [5:0] REG_CMD_SET  = 6'h05;
   localparam logic [5:0] REG_FLAGS    = 6'h0B;
   localparam logic [5:0] REG_LOW_CNT  = 6'h20;
   localparam logic [5:0] REG_HIGH_CNT = 6'h21;
   localparam logic [5:0] REG_LOW_PER  = 6'h26;
   localparam logic [5:0] REG_HIGH_PER = 6'h27;
   localparam logic [5:0] REG_CMP_BASE = 6'h28;
   localparam logic [5:0] REG_CMP_LAST = 6'h2D;
   // field positions
   localparam int EN_BIT  = 0;
   localparam int PSC_LSB = 1;
   localparam int CMD_LSB = 2;
   localparam int HI_LSB  = 4;
   localparam int UNF_LO  = 0;
   localparam int UNF_HI  = 1;
   localparam int MCH_LSB = 4;
   // writable bit masks and reset values
   localparam logic [7:0] CH_MASK   = 8'h77;
   localparam logic [7:0] FLAG_MASK = 8'h73;
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] PER_RST   = 8'hFF;
   localparam logic [7:0] CMP_RST   = 8'h00;
   // command and target codes
   localparam logic [1:0] CMD_RESTART = 2'h2;
   localparam logic [1:0] CMD_HARD    = 2'h3;
   localparam logic [1:0] TGT_BOTH    = 2'h3;
   // prescaler: log2 of the divide ratio per select code
   localparam int PSC_W = 10;
   localparam int PSC_LOG2 [8] = '{0, 1, 2, 3, 4, 6, 8, 10};
endpackage

// [sdbt_half_if.sv]
// sdbt_half_if: control and status between the core and one 8-bit half
// assumes both ends on the same clock
`timescale 1ns/1ns
`default_nettype none
interface sdbt_half_if;
   logic             tick;    // prescaled step
   logic             restart; // reload counter
   logic             hard;    // clear counter and outputs
   logic [7:0]       per;     // top value
   logic [2:0][7:0]  cmp;     // compare values
   logic [7:0]       cnt;     // counter value
   logic [2:0]       match;   // compare match pulses
   logic [2:0]       wave;    // waveform levels
   logic             unf;     // bottom pulse
   modport ctl (output tick, restart, hard, per, cmp,
                input cnt, match, wave, unf);
   modport tmr (input tick, restart, hard, per, cmp,
                output cnt, match, wave, unf);
endinterface
`default_nettype wire

// [sdbt_prescale.sv]
// sdbt_prescale: divides the peripheral clock into a one-cycle tick
// assumes run_i and sel_i come from registers on clk_i
`timescale 1ns/1ns
`default_nettype none
module sdbt_prescale
   import sdbt_pkg::*;
#(
   parameter int DIV_W = PSC_W // divider width
) (
   input  wire logic       clk_i,   // peripheral clock
   input  wire logic       reset_i, // sync reset, high
   input  wire logic       run_i,   // enable
   input  wire logic [2:0] sel_i,   // ratio select
   output logic            tick_o   // one-cycle tick
);
   import sdbt_pkg::*;
   logic [DIV_W-1:0] div;      // free count
   logic [DIV_W-1:0] next_div; // next count
   logic [DIV_W-1:0] mask;     // low bits that must be ones
   // largest ratio needs the full width
   if (DIV_W < PSC_LOG2[7]) begin : g_chk
      $error("sdbt_prescale: DIV_W too small");
   end
   // count only while running, so each start is phase aligned
   always_comb begin
      next_div = run_i ? div + 1'b1 : '0;
      mask = DIV_W'((1 << PSC_LOG2[sel_i]) - 1);
      tick_o = run_i && ((div & mask) == mask);
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) div <= '0;
      else div <= next_div;
   end
endmodule // sdbt_prescale
`default_nettype wire

// [sdbt_half.sv]
// sdbt_half: one 8-bit down counter with three compare channels
// assumes tick, restart and hard are single-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module sdbt_half (
   input  wire logic clk_i,   // peripheral clock
   input  wire logic reset_i, // sync reset, high
   sdbt_half_if.tmr  h        // control from the core
);
   logic [7:0] cnt;      // counter
   logic [7:0] next_cnt; // next counter
   logic       bottom;   // step at zero
   // count down, reload the top value at bottom
   always_comb begin
      bottom = h.tick && (cnt == 8'h00);
      next_cnt = cnt;
      if (h.hard) next_cnt = 8'h00;
      else if (h.restart) next_cnt = h.per;
      else if (bottom) next_cnt = h.per;
      else if (h.tick) next_cnt = cnt - 8'h01;
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) cnt <= 8'h00;
      else cnt <= next_cnt;
   end
   assign h.cnt = cnt;
   assign h.unf = bottom;
   // per channel: match pulse and single-slope waveform
   for (genvar c = 0; c < 3; c++) begin : g_ch
      logic wave;      // output level
      logic next_wave; // next level
      always_comb begin
         next_wave = wave;
         if (h.hard || h.restart) next_wave = 1'b0;
         else if (h.match[c]) next_wave = 1'b1;
         else if (bottom) next_wave = 1'b0;
      end
      always_ff @(posedge clk_i) begin
         if (reset_i) wave <= 1'b0;
         else wave <= next_wave;
      end
      assign h.match[c] = h.tick && (cnt == h.cmp[c]);
      assign h.wave[c] = wave;
   end
endmodule // sdbt_half
`default_nettype wire

// [sdbt_timer.sv]
// sdbt_timer: split dual-byte timer control with an APB register slave
// assumes one clock, APB master on clk_i, port_out_i on clk_i
// How it works
// - select bits 3:1 choose divide by 1..1024
// - enable bit 0 stops or runs timer
// - output enable lets waveform replace port value
// - idle bits drive outputs while timer disabled
// - split bit runs two 8-bit counters
// - clear port clears bits written one
// - set port sets bits written one
// - command 2 restarts, 3 hard-resets
// - command field always reads zero
// - hard reset ignored while enabled
// - only target code 3 selects both halves
// - low compare match sets sticky flag
// - bottom sets sticky underflow flag per half
`timescale 1ns/1ns
`default_nettype none
module sdbt_timer
   import sdbt_pkg::*;
(
   input  wire logic        clk_i,     // 25 MHz clock
   input  wire logic        reset_i,   // sync reset, high
   input  wire logic        psel,      // APB select
   input  wire logic        penable,   // APB access phase
   input  wire logic        pwrite,    // APB write
   input  wire logic [7:0]  paddr,     // APB byte address
   input  wire logic [31:0] pwdata,    // APB write data
   output logic [31:0]      prdata,    // APB read data
   output logic             pready,    // APB ready
   output logic             pslverr,   // APB error
   input  wire logic [5:0]  port_out_i, // port register value
   output logic [5:0]       waveform_output_pin_o // pin levels
);
   import sdbt_pkg::*;

   // configuration registers
   logic [3:0] ctl;       // select and enable
   logic [7:0] out_en;    // channel output enables
   logic [7:0] idle;      // idle levels
   logic       split;     // split mode
   logic [1:0] tgt;       // command target
   logic [3:0] next_ctl;
   logic [7:0] next_out_en;
   logic [7:0] next_idle;
   logic       next_split;
   logic [1:0] next_tgt;
   // period and compare registers per half
   logic [1:0][7:0]      per;
   logic [1:0][2:0][7:0] cmp;
   logic [1:0][7:0]      next_per;
   logic [1:0][2:0][7:0] next_cmp;
   // sticky event flags
   logic [7:0] flags;
   logic [7:0] next_flags;
   // bus response
   logic [31:0] next_prdata;
   logic        next_pslverr;
   // pin drive
   logic [5:0] next_pin;
   // decoded strobes and shared signals
   logic [5:0] idx;        // word index
   logic       setup;      // APB setup cycle
   logic       wr;         // write takes effect
   logic       mapped;     // index answers
   logic       enable;     // enable bit
   logic       run;        // counters may step
   logic       tick;       // shared tick
   logic [1:0] cmd_new;    // command just written
   logic       cmd_fire;   // command for both halves
   logic       restart;    // restart pulse
   logic       hard;       // hard reset pulse
   logic [5:0] wave_lvl;   // generator or idle level
   logic [5:0] wave_all;   // generator outputs

   sdbt_half_if hif [2] ();

   assign idx = paddr[7:2];
   assign setup = psel && !penable;
   assign wr = psel && penable && pready && pwrite;
   assign enable = ctl[EN_BIT];
   // 16-bit layout is not served, so only split mode counts
   assign run = enable && split;

   // one tick feeds both halves, gated by the shared enable
   sdbt_prescale u_psc (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .run_i   (run),
      .sel_i   (ctl[3:PSC_LSB]),
      .tick_o  (tick)
   );

   // two halves, same tick and same commands
   for (genvar g = 0; g < 2; g++) begin : g_half
      assign hif[g].tick = tick;
      assign hif[g].restart = restart;
      assign hif[g].hard = hard;
      assign hif[g].per = per[g];
      assign hif[g].cmp = cmp[g];
      sdbt_half u_half (
         .clk_i   (clk_i),
         .reset_i (reset_i),
         .h       (hif[g])
      );
   end
   assign wave_all = {hif[1].wave, hif[0].wave};

   // command decode: only the value written this cycle acts
   always_comb begin
      cmd_new = 2'h0;
      if (wr && idx == REG_CMD_SET)
         cmd_new = pwdata[CMD_LSB+1:CMD_LSB];
      // clear port leaves a command field that is always zero
      cmd_fire = (next_tgt == TGT_BOTH);
      restart = cmd_fire && (cmd_new == CMD_RESTART);
      hard = cmd_fire && (cmd_new == CMD_HARD)
             && !enable;
   end

   // configuration next values
   always_comb begin
      next_ctl = ctl;
      next_out_en = out_en;
      next_idle = idle;
      next_split = split;
      next_tgt = tgt;
      if (wr) begin
         case (idx)
            REG_PRESCALE: next_ctl = pwdata[3:0];
            REG_OUT_EN:   next_out_en = pwdata[7:0] & CH_MASK;
            REG_IDLE:     next_idle = pwdata[7:0] & CH_MASK;
            REG_SPLIT:    next_split = pwdata[0];
            REG_CMD_CLR:  next_tgt = tgt & ~pwdata[1:0];
            REG_CMD_SET:  next_tgt = tgt | pwdata[1:0];
            default:      next_tgt = tgt;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ctl <= CTRL_RST[3:0];
         out_en <= CTRL_RST;
         idle <= CTRL_RST;
         split <= 1'b0;
         tgt <= 2'h0;
      end else begin
         ctl <= next_ctl;
         out_en <= next_out_en;
         idle <= next_idle;
         split <= next_split;
         tgt <= next_tgt;
      end
   end

   // period and compare; a hard reset puts them back to reset values
   always_comb begin
      next_per = per;
      next_cmp = cmp;
      if (hard) begin
         next_per = {PER_RST, PER_RST};
         next_cmp = '0;
      end else if (wr && split) begin
         if (idx == REG_LOW_PER) next_per[0] = pwdata[7:0];
         if (idx == REG_HIGH_PER) next_per[1] = pwdata[7:0];
         if (idx >= REG_CMP_BASE && idx <= REG_CMP_LAST)
            next_cmp[idx[0]][2'((idx - REG_CMP_BASE) >> 1)] =
               pwdata[7:0];
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         per <= {PER_RST, PER_RST};
         cmp <= '0;
      end else begin
         per <= next_per;
         cmp <= next_cmp;
      end
   end

   // sticky flags: a new event wins over a same-cycle clear
   always_comb begin
      next_flags = flags;
      if (wr && split && idx == REG_FLAGS)
         next_flags = flags & ~pwdata[7:0];
      next_flags[UNF_LO] = next_flags[UNF_LO] | hif[0].unf;
      next_flags[UNF_HI] = next_flags[UNF_HI] | hif[1].unf;
      next_flags[MCH_LSB+2:MCH_LSB] =
         next_flags[MCH_LSB+2:MCH_LSB] | hif[0].match;
      if (hard) next_flags = 8'h00;
      next_flags = next_flags & FLAG_MASK;
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) flags <= 8'h00;
      else flags <= next_flags;
   end

   // read mux, captured in setup so data comes from flip-flops
   always_comb begin
      mapped = 1'b1;
      next_prdata = 32'h0000_0000;
      case (idx)
         REG_PRESCALE: next_prdata[3:0] = ctl;
         REG_OUT_EN:   next_prdata[7:0] = out_en;
         REG_IDLE:     next_prdata[7:0] = idle;
         REG_SPLIT:    next_prdata[0] = split;
         // command bits read as zero, target bits as stored
         REG_CMD_CLR,
         REG_CMD_SET:  next_prdata[1:0] = tgt;
         default:      mapped = 1'b0;
      endcase
      // split layout appears only with the split bit set
      if (split) begin
         mapped = 1'b1;
         case (idx)
            REG_FLAGS:    next_prdata[7:0] = flags;
            REG_LOW_CNT:  next_prdata[7:0] = hif[0].cnt;
            REG_HIGH_CNT: next_prdata[7:0] = hif[1].cnt;
            REG_LOW_PER:  next_prdata[7:0] = per[0];
            REG_HIGH_PER: next_prdata[7:0] = per[1];
            default: begin
               if (idx >= REG_CMP_BASE && idx <= REG_CMP_LAST)
                  next_prdata[7:0] =
                     cmp[idx[0]][2'((idx - REG_CMP_BASE) >> 1)];
               else if (idx > REG_CMD_SET)
                  mapped = 1'b0;
            end
         endcase
      end
      next_pslverr = !mapped;
      if (!setup) begin
         next_prdata = prdata;
         next_pslverr = pslverr;
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end
   // one wait-free access phase after the registered setup
   assign pready = penable;

   // pins: idle levels while stopped, port value unless enabled
   always_comb begin
      wave_lvl = enable ? wave_all
                 : {idle[HI_LSB+2:HI_LSB], idle[2:0]};
      next_pin = port_out_i;
      for (int i = 0; i < 3; i++) begin
         if (out_en[i]) next_pin[i] = wave_lvl[i];
         if (out_en[HI_LSB+i])
            next_pin[3+i] = wave_lvl[3+i];
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) waveform_output_pin_o <= 6'h00;
      else waveform_output_pin_o <= next_pin;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_stop_no_tick: assert property (!run |-> !tick)
      else $error("tick while timer stopped");
   a_div1_every: assert property (
      ($past(run) && run && ctl[3:1] == 3'h0) |-> tick)
      else $error("divide by one missed a tick");
   a_div2_alt: assert property (
      (run && ctl[3:1] == 3'h1 && tick) ##1 run |-> !tick)
      else $error("divide by two ticked twice in a row");
   a_split_gate: assert property (!split |-> !tick)
      else $error("tick outside split mode");
   a_clr_target: assert property (
      (wr && idx == REG_CMD_CLR && pwdata[1:0] == 2'h3)
      |=> tgt == 2'h0)
      else $error("clear port did not clear target");
   a_set_target: assert property (
      (wr && idx == REG_CMD_SET && pwdata[1:0] == 2'h3)
      |=> tgt == 2'h3)
      else $error("set port did not set target");
   a_cmd_zero: assert property (
      (setup && (idx == REG_CMD_SET || idx == REG_CMD_CLR))
      |=> prdata[3:2] == 2'h0)
      else $error("command field read nonzero");
   a_hard_idle: assert property (hard |-> !enable)
      else $error("hard reset while enabled");
   a_restart_load: assert property (
      restart |=> hif[0].cnt == $past(per[0])
              && hif[1].cnt == $past(per[1]))
      else $error("restart did not reload counters");
   a_unf_sticky: assert property (
      hif[1].unf |=> flags[UNF_HI] [*2])
      else $error("high underflow flag not held");
   a_match_flag: assert property (
      (hif[0].match[0] && !hard) |=> flags[MCH_LSB])
      else $error("low match flag not set");
   a_idle_pin: assert property (
      (!enable && out_en[0] && $stable(idle) && $stable(out_en))
      |=> waveform_output_pin_o[0] == $past(idle[0]))
      else $error("idle level not on pin");
   a_wave_pin: assert property (
      (enable && out_en[HI_LSB])
      |=> waveform_output_pin_o[3] == $past(wave_all[3]))
      else $error("waveform not on pin");
   // a quarter-rate tick leaves three quiet cycles
   a_div4_gap: assert property (
      (run && ctl[3:1] == 3'h2 && tick)
      |=> (!tick || ctl[3:1] != 3'h2) [*3])
      else $error("divide by four ticked too soon");
   // a stopped counter only moves on a command
   a_stop_hold: assert property (
      (!run && !restart && !hard)
      |=> hif[0].cnt == $past(hif[0].cnt))
      else $error("counter moved while stopped");
   // a channel without output enable shows the port value
   a_pin_port: assert property (
      !out_en[1]
      |=> waveform_output_pin_o[1] == $past(port_out_i[1]))
      else $error("port value not on pin");
   // split registers refuse access outside split mode
   a_split_map: assert property (
      (setup && !split && idx == REG_LOW_CNT)
      |=> pslverr)
      else $error("split register answered outside split mode");
   // the clear port and idle cycles never issue a command
   a_cmd_only_set: assert property (
      !(wr && idx == REG_CMD_SET) |-> !restart && !hard)
      else $error("command issued outside a set write");
   // low underflow sets its flag, a later write of one clears it
   a_unf_low: assert property (hif[0].unf |=> flags[UNF_LO])
      else $error("low underflow flag not set");
   a_flag_clear: assert property (
      (wr && split && idx == REG_FLAGS && pwdata[UNF_LO]
       && !hif[0].unf && !hard) |=> !flags[UNF_LO])
      else $error("low underflow flag not cleared");
endmodule // sdbt_timer
`default_nettype wire

// [sdbt_timer_tb.sv]
// sdbt_timer_tb: self-checking bench for the split dual-byte timer control
// assumes the design answers apb with zero or more wait states on clk_i
`timescale 1ns/1ns
`default_nettype none
module sdbt_timer_tb;
   import sdbt_pkg::*;
   logic        clk_i      = 1'b0;     // 25 mhz clock
   logic        reset_i    = 1'b1;     // sync reset, high
   logic        psel       = 1'b0;     // apb select
   logic        penable    = 1'b0;     // apb access phase
   logic        pwrite     = 1'b0;     // apb direction
   logic [7:0]  paddr      = 8'h00;    // apb byte address
   logic [31:0] pwdata     = 32'h0;    // apb write data
   logic [5:0]  port_out_i = 6'h2A;    // port register stand-in
   logic [31:0] prdata;                // apb read data
   logic        pready;                // apb ready
   logic        pslverr;               // apb error
   logic [5:0]  pins;                  // pin levels
   int          err_total  = 0;        // mismatches seen
   int          n_checks   = 0;        // comparisons made
   logic [7:0]  rv;                    // last read value
   logic        ev;                    // last error flag
   int          s;                     // counted steps
   logic [7:0]  tgt_tab [4] = '{8'h09, 8'h0A, 8'h08, 8'h07}; // no-op cmds

   sdbt_timer sdbt_timer_inst (
      .clk_i                 (clk_i),
      .reset_i               (reset_i),
      .psel                  (psel),
      .penable               (penable),
      .pwrite                (pwrite),
      .paddr                 (paddr),
      .pwdata                (pwdata),
      .prdata                (prdata),
      .pready                (pready),
      .pslverr               (pslverr),
      .port_out_i            (port_out_i),
      .waveform_output_pin_o (pins)
   );

   // free-running clock, 40 ns period
   initial begin
      forever #20 clk_i = ~clk_i;
   end

   // one comparison, case equality so unknowns never match
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [5:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd,
                      output logic err);
      @(posedge clk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      // no cycle count assumed; only the watchdog ends this wait
      while (pready !== 1'b1) @(posedge clk_i);
      rd = prdata[7:0];
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, rv, ev);
   endtask

   task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00, rv, ev);
      chk(rv, exp);
   endtask

   // unmapped places must answer with an error
   task automatic rderr(input logic [5:0] idx);
      apb(1'b0, idx, 8'h00, rv, ev);
      chk({7'h00, ev}, 8'h01);
   endtask

   // pins are registered, so let two edges pass first
   task automatic pin(input logic [5:0] exp);
      repeat (2) @(posedge clk_i);
      chk({2'b00, pins}, {2'b00, exp});
   endtask

   // counts, verdict and end of run; the only exit point
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // watchdog sized well above the longest prescale sweep
   initial begin
      repeat (60000) @(posedge clk_i);
      err_total++;
      complete_run();
   end

   // main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rdc(i[5:0], CTRL_RST);
      end
      // writable masks of the channel registers
      wr(REG_OUT_EN, 8'hFF);
      rdc(REG_OUT_EN, CH_MASK);
      wr(REG_IDLE, 8'hFF);
      rdc(REG_IDLE, CH_MASK);
      // pin source selection while stopped
      wr(REG_OUT_EN, 8'h00);
      pin(6'h2A);
      wr(REG_OUT_EN, 8'h77);
      wr(REG_IDLE, 8'h35);
      pin(6'h1D);
      wr(REG_OUT_EN, 8'h01);
      pin(6'h2B);
      wr(REG_IDLE, 8'h00);
      wr(REG_OUT_EN, 8'h00);
      // split layout only exists with the split bit set
      rderr(REG_LOW_CNT);
      wr(REG_SPLIT, 8'h01);
      rdc(REG_SPLIT, 8'h01);
      rdc(REG_LOW_PER, PER_RST);
      // set and clear ports touch only bits written one
      wr(REG_CMD_SET, 8'h01);
      rdc(REG_CMD_CLR, 8'h01);
      wr(REG_CMD_SET, 8'h02);
      rdc(REG_CMD_SET, 8'h03);
      wr(REG_CMD_CLR, 8'h01);
      rdc(REG_CMD_SET, 8'h02);
      wr(REG_CMD_SET, 8'h0C);
      rdc(REG_CMD_SET, 8'h02);
      rdc(REG_CMD_CLR, 8'h02);
      // hard reset while stopped clears the counters
      wr(REG_CMD_SET, 8'h0F);
      rdc(REG_LOW_CNT, 8'h00);
      // reserved targets, no target and reserved code do nothing
      for (int i = 0; i < 4; i++) begin
         wr(REG_CMD_CLR, 8'h03);
         wr(REG_CMD_SET, tgt_tab[i]);
         rdc(REG_LOW_CNT, 8'h00);
      end
      // restart with both targets reloads both periods
      wr(REG_CMD_SET, 8'h08);
      rdc(REG_LOW_CNT, 8'hFF);
      rdc(REG_HIGH_CNT, 8'hFF);
      // still stopped: the count must not move
      repeat (100) @(posedge clk_i);
      rdc(REG_LOW_CNT, 8'hFF);
      // every prescale code, about eight ticks each
      for (int c = 0; c < 8; c++) begin
         wr(REG_CMD_SET, 8'h08);
         wr(REG_PRESCALE, {4'h0, c[2:0], 1'b1});
         repeat ((8 << PSC_LOG2[c]) - 2) @(posedge clk_i);
         wr(REG_PRESCALE, {4'h0, c[2:0], 1'b0});
         apb(1'b0, REG_LOW_CNT, 8'h00, rv, ev);
         s = 255 - int'(rv);
         chk({7'h00, s >= 6 && s <= 10}, 8'h01);
         apb(1'b0, REG_HIGH_CNT, 8'h00, rv, ev);
         s = 255 - int'(rv);
         chk({7'h00, s >= 6 && s <= 10}, 8'h01);
      end
      // short periods: underflow and low match flags are sticky
      wr(REG_LOW_PER, 8'h02);
      wr(REG_HIGH_PER, 8'h02);
      wr(6'h28, 8'h01);
      wr(6'h2A, 8'hFE);
      wr(6'h2C, 8'h02);
      wr(REG_CMD_SET, 8'h08);
      wr(REG_PRESCALE, 8'h01);
      repeat (30) @(posedge clk_i);
      wr(REG_PRESCALE, 8'h00);
      rdc(REG_FLAGS, 8'h53);
      wr(REG_FLAGS, 8'h10);
      rdc(REG_FLAGS, 8'h43);
      wr(REG_FLAGS, 8'h43);
      rdc(REG_FLAGS, 8'h00);
      // hard reset refused while running
      wr(REG_PRESCALE, 8'h01);
      wr(REG_CMD_SET, 8'h0F);
      wr(REG_PRESCALE, 8'h00);
      rdc(REG_LOW_PER, 8'h02);
      rdc(6'h28, 8'h01);
      // pins follow the waveform while running, idle levels when stopped
      wr(REG_IDLE, 8'h11);
      wr(REG_OUT_EN, 8'h11);
      pin(6'h2B);
      wr(REG_CMD_SET, 8'h08);
      wr(REG_PRESCALE, 8'h0F);
      pin(6'h22);
      repeat (2400) @(posedge clk_i);
      pin(6'h23);
      wr(REG_PRESCALE, 8'h0E);
      // carried out once stopped
      wr(REG_CMD_SET, 8'h0F);
      rdc(REG_LOW_PER, PER_RST);
      rdc(6'h28, CMP_RST);
      rdc(REG_FLAGS, 8'h00);
      complete_run();
   end
endmodule // sdbt_timer_tb
`default_nettype wire
